// [cpu_flash_model.sv]
`timescale 1ns/1ps
// ****************************************
// cpu side of the flash port
// ****************************************
module cpu_flash_model
	import flash_seq_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       fa_ack_i,
	input  wire logic [7:0] fa_rdata_i,
	output logic            fa_stb_o,
	output flash_req_t      fa_req_o
);
	// idle before the first access
	initial begin
		fa_stb_o = 1'b0;
		fa_req_o = '{we: 1'b0, addr: 16'h0000, wdata: 8'h00};
	end

	// held until ack; released address and data lines show the inverse so a stale value never passes
	task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		fa_stb_o <= 1'b1;
		fa_req_o <= '{we, a, d};
		do begin
			@(posedge clk_i);
		end while (fa_ack_i !== 1'b1);
		q = fa_rdata_i;
		fa_stb_o <= 1'b0;
		fa_req_o <= '{1'b0, ~a, ~d};
		@(posedge clk_i);
	endtask : access

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		access(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] q);
		access(1'b0, a, 8'h00, q);
	endtask : rd

	// unlock pair then a code, all in the area picked by hi
	task automatic cmd(input logic [3:0] hi, input logic [7:0] code);
		wr({hi, 12'h555}, 8'hAA);
		wr({hi, 12'hAAA}, 8'h55);
		wr({hi, 12'h555}, code);
	endtask : cmd
endmodule : cpu_flash_model

// [flash_command_sequencer.sv]
`timescale 1ns/1ps
`include "flash_seq_map.svh"
module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int         ERASE_CYCLES = `FCS_ERASE_CYC,
	parameter int         PROG_CYCLES  = `FCS_PROG_CYC,
	parameter logic [7:0] VENDOR_ID    = 8'h5A,   // arbitrary value
	parameter logic [7:0] MACRO_ID     = 8'h3C    // arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// register bus, classic wishbone
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// cpu flash access
	input  wire logic        fa_stb_i,
	input  wire flash_req_t  fa_req_i,
	output logic      [7:0]  fa_rdata_o,
	output logic             fa_ack_o,
	// system side
	input  wire logic        parallel_mode_i,
	input  wire logic        ram_exec_i,
	input  wire logic        irq_i,
	input  wire logic        low_power_entry_i,
	input  wire logic        low_power_i,
	output logic             flash_current_off_o,
	output logic             busy_o
);
	localparam int TW = 21;
	localparam logic [TW-1:0] PROG_CNT  = TW'(PROG_CYCLES);
	localparam logic [TW-1:0] ERASE_CNT = TW'(ERASE_CYCLES);

	// ****************************************
	// pin synchroniser
	// ****************************************
	logic par_meta_reg;
	logic par_reg;

	// mode strap comes from a pin, so two flops before use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			par_meta_reg <= 1'b0;
			par_reg      <= 1'b0;
		end else if (ce_i) begin
			par_meta_reg <= parallel_mode_i;
			par_reg      <= par_meta_reg;
		end
	end

	// ****************************************
	// register bus slave
	// ****************************************
	logic [3:0]  cmd_exec_enable_field;
	logic        flash_standby_bit;
	logic        wb_ack_reg;
	logic [31:0] wb_dat_reg;
	logic        wb_take;
	logic        wb_wr;
	logic        busy;
	logic        id_mode_reg;
	logic        protect_reg;
	logic        cmd_ok;

	assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
	assign wb_wr   = wb_take & wb_we_i & wb_sel_i[0];

	// one wait state: ack rises the cycle after the strobe and drops after one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_reg <= 1'b0;
		end else if (ce_i) begin
			wb_ack_reg <= wb_take;
		end
	end

	// enable field; a reset closes the gate so stray code cannot erase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_exec_enable_field <= `FCS_EN_CODE_OFF;                    // [RULE4]
		end else if (ce_i && wb_wr && wb_adr_i == `FCS_REG_CTRL) begin
			cmd_exec_enable_field <= wb_dat_i[`FCS_EN_LSB +: 4];
		end
	end

	// read data; unmapped words answer zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_reg <= 32'h0000_0000;
		end else if (ce_i && wb_take) begin
			case (wb_adr_i)
				`FCS_REG_CTRL: begin
					wb_dat_reg <= {24'h00_0000, cmd_exec_enable_field, 4'h0};
				end
				`FCS_REG_STANDBY: begin
					wb_dat_reg <= {31'h0000_0000, flash_standby_bit};
				end
				`FCS_REG_STATUS: begin
					wb_dat_reg <= {27'h000_0000, cmd_ok, par_reg, protect_reg,
						id_mode_reg, busy};
				end
				default: begin
					wb_dat_reg <= 32'h0000_0000;
				end
			endcase
		end
	end

	assign wb_ack_o = wb_ack_reg;
	assign wb_dat_o = wb_dat_reg;

	// ****************************************
	// flash standby
	// ****************************************
	logic fa_ack_reg;
	logic fa_take;
	logic cur_off_reg;

	assign fa_take = fa_stb_i & ~fa_ack_reg;

	// hardware clears win over a software set in the same cycle, since an
	// access to a powered-down array would return garbage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_standby_bit <= 1'b0;
		end else if (ce_i) begin
			if (fa_take) begin
				flash_standby_bit <= 1'b0;                                 // [RULE15]
			end else if (irq_i) begin
				flash_standby_bit <= 1'b0;                                 // [RULE16]
			end else if (low_power_entry_i) begin
				flash_standby_bit <= 1'b0;                                 // [RULE17]
			end else if (wb_wr && wb_adr_i == `FCS_REG_STANDBY) begin
				if (!wb_dat_i[`FCS_STB_BIT]) begin
					flash_standby_bit <= 1'b0;
				end else if (ram_exec_i) begin
					flash_standby_bit <= 1'b1;                             // [RULE18]
				end
			end
		end
	end

	// low-power modes cut the current whatever the bit says
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_off_reg <= 1'b0;
		end else if (ce_i) begin
			cur_off_reg <= flash_standby_bit | low_power_i;               // [RULE17]
		end
	end

	assign flash_current_off_o = cur_off_reg;

	// ****************************************
	// command decode
	// ****************************************
	seq_state_t  state_reg;
	seq_state_t  state_next;
	logic        in_array;
	logic        wr_take;
	logic [11:0] lo_adr;
	logic [7:0]  wd;
	logic        is_unlock1;
	logic        is_unlock2;
	logic        start_prog;
	logic        start_sector;
	logic        start_chip;
	logic        start_protect;
	logic        id_set;
	logic        id_clr;

	// the gate only matters outside parallel programmer mode
	assign cmd_ok   = par_reg | (cmd_exec_enable_field == `FCS_EN_CODE_ON); // [RULE2] [RULE3]
	assign in_array = (fa_req_i.addr[15:14] == `FCS_ARRAY_BASE_HI);        // [RULE1]
	// writes during an operation or with the gate shut are dropped
	assign wr_take  = fa_take & fa_req_i.we & in_array & cmd_ok & ~busy;  // [RULE5] [RULE22]
	assign lo_adr   = fa_req_i.addr[11:0];                                 // [RULE7]
	assign wd       = fa_req_i.wdata;
	assign is_unlock1 = (lo_adr == `FCS_ADDR_UNLOCK1) && (wd == `FCS_D_UNLOCK1); // [RULE9]
	assign is_unlock2 = (lo_adr == `FCS_ADDR_UNLOCK2) && (wd == `FCS_D_UNLOCK2); // [RULE9]

	// next state and the one-cycle starts; any wrong cycle abandons the sequence
	always_comb begin
		state_next    = SEQ_IDLE;
		start_prog    = 1'b0;
		start_sector  = 1'b0;
		start_chip    = 1'b0;
		start_protect = 1'b0;
		id_set        = 1'b0;
		id_clr        = 1'b0;
		case (state_reg)
			SEQ_IDLE: begin
				if (wd == `FCS_D_ID_EXIT) begin
					id_clr = 1'b1;                                         // [RULE14]
				end else if (is_unlock1) begin
					state_next = SEQ_UNLOCKED;
				end
			end
			SEQ_UNLOCKED: begin
				if (is_unlock2) begin
					state_next = SEQ_CMD;
				end
			end
			SEQ_CMD: begin
				if (lo_adr == `FCS_ADDR_UNLOCK1) begin
					case (wd)
						`FCS_D_PROG:     state_next = SEQ_PROG_DATA;        // [RULE10]
						`FCS_D_ERASE:    state_next = SEQ_ERASE_ARMED;      // [RULE11]
						`FCS_D_PROTECT:  state_next = SEQ_PROTECT_CONF;     // [RULE12]
						`FCS_D_ID_ENTRY: id_set = 1'b1;                     // [RULE13]
						`FCS_D_ID_EXIT:  id_clr = 1'b1;                     // [RULE14]
						default:         state_next = SEQ_IDLE;
					endcase
				end
			end
			SEQ_PROG_DATA: begin
				start_prog = 1'b1;                                         // [RULE10]
			end
			SEQ_ERASE_ARMED: begin
				if (is_unlock1) begin
					state_next = SEQ_ERASE_UNLOCKED;
				end
			end
			SEQ_ERASE_UNLOCKED: begin
				if (is_unlock2) begin
					state_next = SEQ_ERASE_CMD;
				end
			end
			SEQ_ERASE_CMD: begin
				// sector erase has no meaning in parallel programmer mode
				if (wd == `FCS_D_SECTOR && !par_reg) begin
					start_sector = 1'b1;                                   // [RULE11]
				end else if (lo_adr == `FCS_ADDR_UNLOCK1 && wd == `FCS_D_CHIP) begin
					start_chip = 1'b1;                                     // [RULE13]
				end
			end
			SEQ_PROTECT_CONF: begin
				// full address compare here, not the low 12 bits
				if (fa_req_i.addr == `FCS_ADDR_PROTECT && wd == `FCS_D_PROTECT_CONF) begin
					start_protect = 1'b1;                                  // [RULE12]
				end
			end
			default: begin
				state_next = SEQ_IDLE;
			end
		endcase
	end

	// sequence position advances only on an accepted write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= SEQ_IDLE;
		end else if (ce_i) begin
			if (!cmd_ok) begin
				state_reg <= SEQ_IDLE;                                     // [RULE5]
			end else if (wr_take) begin
				state_reg <= state_next;
			end
		end
	end

	// id mode flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_mode_reg <= 1'b0;
		end else if (ce_i && wr_take) begin
			if (id_set) begin
				id_mode_reg <= 1'b1;                                       // [RULE13]
			end else if (id_clr) begin
				id_mode_reg <= 1'b0;                                       // [RULE14]
			end
		end
	end

	// ****************************************
	// operation timing and erase walk
	// ****************************************
	logic          timer_load;
	logic [TW-1:0] timer_val;
	logic          timer_run;
	logic          walk_reg;
	logic [13:0]   walk_ptr_reg;
	logic [13:0]   walk_end_reg;
	logic          tog_reg;

	assign timer_load = wr_take & (start_prog | start_protect | start_sector | start_chip);
	assign timer_val  = (start_prog | start_protect) ? PROG_CNT : ERASE_CNT;

	op_timer #(
		.WIDTH      (TW)
	) u_timer (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.load_i     (timer_load),
		.load_val_i (timer_val),
		.running_o  (timer_run)
	);

	// busy until both the time budget and the erase walk are over
	assign busy   = timer_run | walk_reg;                                 // [RULE22]
	assign busy_o = busy;

	// erase walk writes FFH one byte per cycle over the chosen range
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			walk_reg     <= 1'b0;
			walk_ptr_reg <= 14'h0000;
			walk_end_reg <= 14'h0000;
		end else if (ce_i) begin
			if (wr_take && start_sector) begin
				walk_reg     <= 1'b1;
				walk_ptr_reg <= {fa_req_i.addr[13:12], 12'h000};          // [RULE8]
				walk_end_reg <= {fa_req_i.addr[13:12], 12'hFFF};
			end else if (wr_take && start_chip) begin
				walk_reg     <= 1'b1;
				walk_ptr_reg <= 14'h0000;
				walk_end_reg <= 14'h3FFF;                                  // [RULE23]
			end else if (walk_reg) begin
				walk_reg     <= (walk_ptr_reg != walk_end_reg);
				walk_ptr_reg <= walk_ptr_reg + 14'h0001;
			end
		end
	end

	// read protection is set by its command; a chip erase or a reset lifts it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			protect_reg <= 1'b0;
		end else if (ce_i && wr_take) begin
			if (start_protect) begin
				protect_reg <= 1'b1;                                       // [RULE12]
			end else if (start_chip) begin
				protect_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// array and cpu read path
	// ****************************************
	logic [7:0]  mem [0:`FCS_ARRAY_BYTES-1];
	logic [13:0] idx;
	logic [7:0]  rd_byte;
	logic [7:0]  rd_reg;

	assign idx = fa_req_i.addr[13:0];

	// programming can only clear bits, as real cells do
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (walk_reg) begin
				mem[walk_ptr_reg] <= `FCS_D_ERASED;                        // [RULE23]
			end else if (wr_take && start_prog) begin
				mem[idx] <= mem[idx] & wd;                                 // [RULE10]
			end
		end
	end

	// toggle starts at one so the first poll read shows bit 6 high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tog_reg <= 1'b1;
		end else if (ce_i) begin
			if (timer_load) begin
				tog_reg <= 1'b1;                                           // [RULE21]
			end else if (fa_take && !fa_req_i.we && busy) begin
				tog_reg <= ~tog_reg;                                       // [RULE21]
			end
		end
	end

	// read source: busy poll, id table or plain array
	always_comb begin
		rd_byte = mem[idx];
		if (busy) begin
			rd_byte[`FCS_BUSY_BIT] = tog_reg;                              // [RULE21]
		end else if (id_mode_reg) begin
			case (fa_req_i.addr)
				`FCS_ID_VENDOR_ADR: rd_byte = VENDOR_ID;
				`FCS_ID_MACRO_ADR:  rd_byte = MACRO_ID;
				`FCS_ID_SIZE_ADR:   rd_byte = `FCS_ID_SIZE_16K;
				`FCS_ADDR_PROTECT:  rd_byte = protect_reg ? `FCS_ID_PROT : `FCS_ID_UNPROT;
				default:            rd_byte = mem[idx];
			endcase
		end
	end

	// access answers one cycle after the strobe; outside the array reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fa_ack_reg <= 1'b0;
			rd_reg     <= 8'h00;
		end else if (ce_i) begin
			fa_ack_reg <= fa_take;
			if (fa_take && !fa_req_i.we) begin
				rd_reg <= in_array ? rd_byte : 8'h00;
			end
		end
	end

	assign fa_ack_o   = fa_ack_reg;
	assign fa_rdata_o = rd_reg;
endmodule : flash_command_sequencer

// [flash_seq_assertions.sv]
`timescale 1ns/1ps
// ****************************************
// flash sequencer checker
// ****************************************
module flash_seq_checker
	import flash_seq_pkg::*;
#(
	parameter int ERASE_CYCLES = 1200000,
	parameter int PROG_CYCLES  = 1600
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        fa_stb_i,
	input wire flash_req_t  fa_req_i,
	input wire logic [7:0]  fa_rdata_o,
	input wire logic        fa_ack_o,
	input wire logic        parallel_mode_i,
	input wire logic        ram_exec_i,
	input wire logic        irq_i,
	input wire logic        low_power_entry_i,
	input wire logic        low_power_i,
	input wire logic        flash_current_off_o,
	input wire logic        busy_o
);
	// chip erase walks the whole array, so it may outlast the erase count
	localparam int LONGEST  = (ERASE_CYCLES > 16384) ? ERASE_CYCLES : 16384;
	localparam int BUSY_MAX = LONGEST + PROG_CYCLES;
	logic gate_open_reg;
	logic busy_rd_reg;
	logic toggle_seen_reg;
	logic toggle_last_reg;
	int   busy_cnt_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// gate follows the last control write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			gate_open_reg <= 1'b0;
		else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
			gate_open_reg <= (wb_dat_i[7:4] == 4'h3);
	end

	// bit 6 of the previous poll; forgotten once the operation ends
	always_ff @(posedge clk_i) begin
		busy_rd_reg <= fa_stb_i && !fa_ack_o && !fa_req_i.we && busy_o && !rst_i;
		if (rst_i)
			toggle_seen_reg <= 1'b0;
		else if (fa_ack_o && busy_rd_reg) begin
			toggle_seen_reg <= 1'b1;
			toggle_last_reg <= fa_rdata_o[6];
		end else if (!busy_o)
			toggle_seen_reg <= 1'b0;
	end

	// length of the current busy stretch
	always_ff @(posedge clk_i) begin
		if (rst_i || !busy_o)
			busy_cnt_reg <= 0;
		else
			busy_cnt_reg <= busy_cnt_reg + 1;
	end

	sequence s_fa_take;
		fa_stb_i && !fa_ack_o;
	endsequence
	sequence s_awake;
		!low_power_i;
	endsequence

	outside_zero_a: assert property (fa_stb_i && !fa_ack_o && !fa_req_i.we
		&& fa_req_i.addr[15:14] != 2'b11 |=> fa_rdata_o == 8'h00)
		else $error("read outside the array returned data");
	gate_busy_a: assert property (disable iff (rst_i || parallel_mode_i)
		$rose(busy_o) |-> gate_open_reg)
		else $error("operation started with the gate shut");
	access_clear_a: assert property (s_fa_take ##1 s_awake |=> !flash_current_off_o)
		else $error("flash access left standby set");
	irq_clear_a: assert property (irq_i ##1 s_awake |=> !flash_current_off_o)
		else $error("interrupt left standby set");
	entry_clear_a: assert property (low_power_entry_i ##1 s_awake |=> !flash_current_off_o)
		else $error("low power entry left standby set");
	lp_cut_a: assert property (low_power_i |=> flash_current_off_o)
		else $error("low power mode did not cut flash current");
	flash_set_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
		&& wb_adr_i == 8'h04 && !ram_exec_i && !flash_current_off_o && !low_power_i
		|=> (!flash_current_off_o)[*3])
		else $error("standby set from flash code");
	toggle_first_a: assert property (fa_ack_o && busy_rd_reg && !toggle_seen_reg
		|-> fa_rdata_o[6])
		else $error("first poll bit 6 not one");
	toggle_flip_a: assert property (fa_ack_o && busy_rd_reg && toggle_seen_reg
		|-> fa_rdata_o[6] != toggle_last_reg)
		else $error("poll bit 6 did not toggle");
	busy_bound_a: assert property (busy_cnt_reg <= BUSY_MAX)
		else $error("operation ran too long");
endmodule : flash_seq_checker

bind flash_command_sequencer flash_seq_checker #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.PROG_CYCLES (PROG_CYCLES)
) i_checker (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .fa_stb_i, .fa_req_i, .fa_rdata_o, .fa_ack_o, .parallel_mode_i,
	.ram_exec_i, .irq_i, .low_power_entry_i, .low_power_i, .flash_current_off_o, .busy_o
);

// [flash_seq_map.svh]
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
// Operation
// (RULE1) 16 KiB array at C000H through FFFFH
// (RULE2) control register gates only outside parallel mode
// (RULE3) commands run only with enable code 0011B
// (RULE4) reset loads enable field with 1100B
// (RULE5) disabled gate ignores every command write
// (RULE6) software keeps the disable code normally
// (RULE7) match only low 12 address bits
// (RULE8) upper 4 address bits select area
// (RULE9) unlock AAH at 555H, 55H at AAAH
// (RULE10) byte program: unlock, A0H, data write
// (RULE11) sector erase: 80H, unlock, 30H at sector
// (RULE12) read protect: A5H, then 00H at FF7FH
// (RULE13) chip erase 10H, id entry 90H
// (RULE14) id exit: F0H anywhere or unlocked F0H
// (RULE15) flash access clears the standby bit
// (RULE16) interrupt clears standby before vector fetch
// (RULE17) low-power entry clears standby, cuts current
// (RULE18) only RAM-resident code may set standby
// (RULE19) software disables interrupts before standby
// (RULE20) software clears standby before returning
// (RULE21) busy reads toggle bit 6, first 1
// (RULE22) erase within 30 ms, commands blocked meanwhile
// (RULE23) chip erase leaves every byte FFH

// ****************************************
// array geometry
// ****************************************
`define FCS_ARRAY_BYTES    16384
`define FCS_ARRAY_BASE_HI  2'h3
`define FCS_SECTOR_BYTES   4096

// ****************************************
// register map (byte addresses)
// ****************************************
`define FCS_REG_CTRL       8'h00
`define FCS_REG_STANDBY    8'h04
`define FCS_REG_STATUS     8'h08
`define FCS_EN_LSB         4
`define FCS_EN_CODE_ON     4'h3
`define FCS_EN_CODE_OFF    4'hC
`define FCS_STB_BIT        0

// ****************************************
// command encoding
// ****************************************
`define FCS_ADDR_UNLOCK1   12'h555
`define FCS_ADDR_UNLOCK2   12'hAAA
`define FCS_ADDR_PROTECT   16'hFF7F
`define FCS_D_UNLOCK1      8'hAA
`define FCS_D_UNLOCK2      8'h55
`define FCS_D_PROG         8'hA0
`define FCS_D_ERASE        8'h80
`define FCS_D_SECTOR       8'h30
`define FCS_D_CHIP         8'h10
`define FCS_D_ID_ENTRY     8'h90
`define FCS_D_ID_EXIT      8'hF0
`define FCS_D_PROTECT      8'hA5
`define FCS_D_PROTECT_CONF 8'h00
`define FCS_D_ERASED       8'hFF
`define FCS_BUSY_BIT       6

// ****************************************
// id mode addresses and answers
// ****************************************
`define FCS_ID_VENDOR_ADR  16'hF000
`define FCS_ID_MACRO_ADR   16'hF001
`define FCS_ID_SIZE_ADR    16'hF002
`define FCS_ID_SIZE_16K    8'h03
`define FCS_ID_UNPROT      8'hFF
`define FCS_ID_PROT        8'h00

// ****************************************
// timing
// ****************************************
`define FCS_CLK_KHZ        40000
`define FCS_PROG_US        40
`define FCS_ERASE_MS       30
`define FCS_PROG_CYC       ((`FCS_PROG_US * `FCS_CLK_KHZ) / 1000)
`define FCS_ERASE_CYC      (`FCS_ERASE_MS * `FCS_CLK_KHZ)
`endif

// [flash_seq_pkg.sv]
package flash_seq_pkg;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_UNLOCKED,
		SEQ_CMD,
		SEQ_PROG_DATA,
		SEQ_ERASE_ARMED,
		SEQ_ERASE_UNLOCKED,
		SEQ_ERASE_CMD,
		SEQ_PROTECT_CONF
	} seq_state_t;

	// one flash bus access from the cpu
	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} flash_req_t;
endpackage : flash_seq_pkg

// [op_timer.sv]
`timescale 1ns/1ps
// ****************************************
// operation timer
// ****************************************
module op_timer #(
	parameter int WIDTH = 21
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] load_val_i,
	output logic                  running_o
);
	logic [WIDTH-1:0] count_reg;

	// counts down once per enabled cycle; a load restarts it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= '0;
		end else if (ce_i) begin
			if (load_i) begin
				count_reg <= load_val_i;
			end else if (count_reg != '0) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	assign running_o = (count_reg != '0);
endmodule : op_timer

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
	import flash_seq_pkg::*;
	typedef struct {logic [15:0] addr; logic [7:0] data; logic [7:0] exp;} prog_row_t;
	localparam int         ERASE_CYC = 20000;
	localparam int         PROG_CYC  = 16;
	localparam logic [7:0] VENDOR    = 8'h6B; // arbitrary value
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        fa_stb_i, fa_ack_o, ram_exec_i, irq_i, low_power_entry_i, low_power_i;
	logic        flash_current_off_o, busy_o, parallel_mode_i;
	logic [7:0]  wb_adr_i, fa_rdata_o, q;
	logic [31:0] wb_dat_i, wb_dat_o, wb_q;
	flash_req_t  fa_req_i;
	int          n_errors = 0;
	int          cmp_count = 0;
	prog_row_t   rows [3] = '{'{16'hC123, 8'h5A, 8'h5A}, '{16'hD456, 8'h0F, 8'h0F},
		'{16'hFFFF, 8'h3C, 8'h3C}};

	flash_command_sequencer #(.ERASE_CYCLES(ERASE_CYC), .PROG_CYCLES(PROG_CYC),
		.VENDOR_ID(VENDOR)) i_dut (
		.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .fa_stb_i, .fa_req_i, .fa_rdata_o,
		.fa_ack_o, .parallel_mode_i, .ram_exec_i, .irq_i, .low_power_entry_i,
		.low_power_i, .flash_current_off_o, .busy_o);
	cpu_flash_model i_cpu (.clk_i, .fa_ack_i(fa_ack_o), .fa_rdata_i(fa_rdata_o),
		.fa_stb_o(fa_stb_i), .fa_req_o(fa_req_i));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// classic cycle, held until ack; data lines inverted once released
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_dat_i <= ~d;
		@(posedge clk_i);
	endtask : wb

	task automatic wait_idle;
		int n = 0;
		while (busy_o !== 1'b0 && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
		check("busy end", busy_o, 1'b0);
	endtask : wait_idle

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// a hang counts as a mismatch
	initial begin
		repeat (90000) @(posedge clk_i);
		n_errors++;
		conclude();
	end

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ram_exec_i, irq_i} = 6'h20;
		{parallel_mode_i, low_power_entry_i, low_power_i, wb_adr_i, wb_dat_i} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 8'h00, 32'h0);
		check("enable field", wb_q[7:4], 4'hC);
		i_cpu.cmd(4'hC, 8'h80);
		i_cpu.cmd(4'hC, 8'h10);
		check("gate shut busy", busy_o, 1'b0);
		wb(1'b1, 8'h00, 32'h30);
		i_cpu.cmd(4'hC, 8'h80); // upper nibbles differ, only low 12 bits match
		i_cpu.cmd(4'hD, 8'h10);
		i_cpu.rd(16'hC001, q);
		check("first poll", q[6], 1'b1);
		i_cpu.rd(16'hC001, q);
		check("second poll", q[6], 1'b0);
		i_cpu.cmd(4'hC, 8'hA0); // program attempt while busy is dropped
		i_cpu.wr(16'hC001, 8'h00);
		wait_idle();
		i_cpu.rd(16'hC001, q);
		check("erased", q, 8'hFF);
		i_cpu.rd(16'h8000, q);
		check("outside array", q, 8'h00);
		foreach (rows[i]) begin
			i_cpu.cmd(4'hF, 8'hA0);
			i_cpu.wr(rows[i].addr, rows[i].data);
			wait_idle();
			i_cpu.rd(rows[i].addr, q);
			check("program", q, rows[i].exp);
		end
		i_cpu.cmd(4'hC, 8'h80);
		i_cpu.cmd(4'hD, 8'h30); // sector picked by the upper bits
		wait_idle();
		i_cpu.rd(16'hD456, q);
		check("sector erased", q, 8'hFF);
		i_cpu.rd(16'hC123, q);
		check("other sector", q, 8'h5A);
		i_cpu.cmd(4'hF, 8'h90);
		i_cpu.rd(16'hF000, q);
		check("vendor id", q, VENDOR);
		i_cpu.rd(16'hFF7F, q);
		check("unprotected", q, 8'hFF);
		i_cpu.wr(16'hE234, 8'hF0);
		i_cpu.rd(16'hFFFF, q);
		check("short id exit", q, 8'h3C);
		i_cpu.cmd(4'hE, 8'hA5);
		i_cpu.wr(16'hFF7F, 8'h00);
		wait_idle();
		i_cpu.cmd(4'hF, 8'h90);
		i_cpu.rd(16'hFF7F, q);
		check("protected", q, 8'h00);
		i_cpu.cmd(4'hC, 8'hF0);
		i_cpu.rd(16'hF000, q);
		check("long id exit", q, 8'hFF);
		wb(1'b1, 8'h00, 32'hC0);
		parallel_mode_i <= 1'b1; // the gate stays shut here
		repeat (3) @(posedge clk_i);
		i_cpu.cmd(4'hC, 8'h80);
		i_cpu.cmd(4'hF, 8'h30);
		check("parallel sector erase", busy_o, 1'b0);
		i_cpu.cmd(4'hF, 8'hA0);
		i_cpu.wr(16'hF123, 8'h96);
		wait_idle();
		i_cpu.rd(16'hF123, q);
		check("parallel program", q, 8'h96);
		wb(1'b0, 8'h08, 32'h0);
		check("status", wb_q[4:0], 5'h1C);
		parallel_mode_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		wb(1'b1, 8'h04, 32'h1);
		repeat (2) @(posedge clk_i);
		check("standby from flash", flash_current_off_o, 1'b0);
		ram_exec_i <= 1'b1; // irq_i is pulsed on the second pass while standby is set
		for (int k = 0; k < 3; k++) begin
			wb(1'b1, 8'h04, 32'h1);
			repeat (2) @(posedge clk_i);
			check("standby from ram", flash_current_off_o, 1'b1);
			if (k == 0)
				i_cpu.rd(16'hC123, q);
			else begin
				irq_i <= (k == 1);
				low_power_entry_i <= (k == 2);
				@(posedge clk_i);
				irq_i <= 1'b0;
				low_power_entry_i <= 1'b0;
			end
			repeat (3) @(posedge clk_i);
			check("standby cleared", flash_current_off_o, 1'b0);
		end
		low_power_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("low power cut", flash_current_off_o, 1'b1);
		low_power_i <= 1'b0;
		wb(1'b1, 8'h04, 32'h0);
		ram_exec_i <= 1'b0;
		conclude();
	end
endmodule : testbench
